// ==== spicsf_pkg.sv ====
// Package of constants and carriers for the serial port control and status flags.
// Functional notes
// R1 - Set mode fault and interrupt when enabled master, select mode 01, select low.
// R2 - Mode fault is never cleared by hardware; software writes it to zero.
// R3 - Overrun only in slave mode: byte arrives while receive buffer unread.
// R4 - Control bit zero enables the interface; reset leaves it disabled.
// R5 - Transfer done flag sets per byte and stays until software clears it.
package spicsf_pkg;
	localparam logic [7:0] SPICSF_CTRL_ADDR = 8'hF8;
	localparam logic [7:0] SPICSF_CTRL_RESET = 8'h06;
	localparam int SPICSF_BIT_DONE = 7;
	localparam int SPICSF_BIT_WRITE_COLLISION_FLAG = 6;
	localparam int SPICSF_BIT_MODE_FAULT_FLAG = 5;
	localparam int SPICSF_BIT_OVR = 4;
	localparam int SPICSF_BIT_SEL_HI = 3;
	localparam int SPICSF_BIT_SEL_LO = 2;
	localparam int SPICSF_BIT_TXE = 1;
	localparam int SPICSF_BIT_EN = 0;
	localparam logic [1:0] SPICSF_SEL_THREE_WIRE = 2'h0;
	localparam logic [1:0] SPICSF_SEL_FOUR_WIRE_SLAVE = 2'h1;
	localparam int SPICSF_BYTE_BITS = 8;
	localparam logic [7:0] SPICSF_ZERO_BYTE = 8'h00;

	typedef struct packed {
		logic transfer_done_flag;
		logic write_collision_flag;
		logic mode_fault_flag;
		logic receive_overrun_flag;
		logic [1:0] select_mode_field;
		logic transmit_buffer_empty;
		logic interface_enable;
	} spicsf_ctrl_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
		logic bit_wr;
		logic [2:0] bit_idx;
		logic bit_val;
	} spicsf_sfr_req_t;
endpackage : spicsf_pkg

// ==== spicsf_link.sv ====
// Link side receive shifter clocked by the serial clock of the other party.
`timescale 1ns/1ps
module spicsf_link
	import spicsf_pkg::*;
#(
	parameter int BYTE_BITS = SPICSF_BYTE_BITS
) (
	// Link clock from the other party and reset from the system side
	input wire logic sck,
	input wire logic rstn,
	// Link pins
	input wire logic slave_select_input_n,
	input wire logic mosi,
	// Towards the system domain
	output logic [BYTE_BITS-1:0] rx_byte,
	output logic byte_toggle
);
	localparam int CW = $clog2(BYTE_BITS);
	localparam logic [CW-1:0] LAST_BIT = CW'(BYTE_BITS - 1);
	localparam logic [CW-1:0] CNT_ZERO = '0;
	localparam logic [CW-1:0] CNT_ONE = CW'(1);

	logic lrst_meta_reg;
	logic lrst_n_reg;
	logic [CW-1:0] cnt_reg;
	logic [BYTE_BITS-1:0] shift_reg;

	// The system reset is a level, so two flops carry it into the link domain.
	always_ff @(posedge sck) begin
		lrst_meta_reg <= rstn;
		lrst_n_reg <= lrst_meta_reg;
	end

	// The frame's own select signal ends a partial byte, since the clock stops between frames.
	always_ff @(posedge sck or posedge slave_select_input_n) begin
		if (slave_select_input_n) begin
			cnt_reg <= CNT_ZERO;
		end else if (!lrst_n_reg) begin
			cnt_reg <= CNT_ZERO;
		end else if (cnt_reg == LAST_BIT) begin
			cnt_reg <= CNT_ZERO;
		end else begin
			cnt_reg <= cnt_reg + CNT_ONE;
		end
	end

	always_ff @(posedge sck) begin
		if (!lrst_n_reg) begin
			shift_reg <= '0;
		end else if (!slave_select_input_n) begin
			shift_reg <= {shift_reg[BYTE_BITS-2:0], mosi};
		end
	end

	// The byte stays still for a whole byte time after the toggle, so the system side reads it safely.
	always_ff @(posedge sck) begin
		if (!lrst_n_reg) begin
			rx_byte <= '0;
			byte_toggle <= 1'b0;
		end else if (!slave_select_input_n && cnt_reg == LAST_BIT) begin
			rx_byte <= {shift_reg[BYTE_BITS-2:0], mosi};
			byte_toggle <= ~byte_toggle;
		end
	end
endmodule : spicsf_link

// ==== spicsf_top.sv ====
// Control and status register of the serial port with its error and completion flags.
`timescale 1ns/1ps
module spicsf_top
	import spicsf_pkg::*;
#(
	parameter int BYTE_BITS = SPICSF_BYTE_BITS
) (
	// System clock, reset and clock enable
	input wire logic clk,
	input wire logic rstn,
	input wire logic ce,
	// Special function register access
	input wire spicsf_sfr_req_t sfr_req,
	output logic [7:0] sfr_rdata,
	// Data register strobes and shifter events
	input wire logic data_wr,
	input wire logic [BYTE_BITS-1:0] data_wdata,
	input wire logic data_rd,
	input wire logic tx_load,
	input wire logic master_byte_done,
	input wire logic master_enable,
	// Link pins
	input wire logic sck,
	input wire logic slave_select_input_n,
	input wire logic mosi,
	// Status towards the rest of the port
	output spicsf_ctrl_t ctrl,
	output logic [BYTE_BITS-1:0] tx_data,
	output logic [BYTE_BITS-1:0] rx_data,
	output logic rx_full,
	output logic irq_request
);
	logic [BYTE_BITS-1:0] link_byte;
	logic link_toggle;
	logic tog_meta_reg;
	logic tog_sync_reg;
	logic tog_prev_reg;
	logic nss_meta_reg;
	logic nss_sync_reg;
	logic slave_byte_done;
	logic byte_done;
	logic hit_wr;
	logic [7:0] wr_byte;
	logic [7:0] cur_byte;
	spicsf_ctrl_t ctrl_next;
	logic mode_fault_flag_set;
	logic ovr_set;
	logic write_collision_flag_set;

	spicsf_link #(
		.BYTE_BITS(BYTE_BITS)
	) u_link (
		.sck(sck),
		.rstn(rstn),
		.slave_select_input_n(slave_select_input_n),
		.mosi(mosi),
		.rx_byte(link_byte),
		.byte_toggle(link_toggle)
	);

	// Byte event from the link arrives as a toggle and is synchronised before use.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			tog_meta_reg <= 1'b0;
			tog_sync_reg <= 1'b0;
			tog_prev_reg <= 1'b0;
		end else if (ce) begin
			tog_meta_reg <= link_toggle;
			tog_sync_reg <= tog_meta_reg;
			tog_prev_reg <= tog_sync_reg;
		end
	end

	// The select pin is asynchronous to the system clock.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			nss_meta_reg <= 1'b1;
			nss_sync_reg <= 1'b1;
		end else if (ce) begin
			nss_meta_reg <= slave_select_input_n;
			nss_sync_reg <= nss_meta_reg;
		end
	end

	// R4 enable gates events
	assign slave_byte_done = ce && ctrl.interface_enable && !master_enable &&
		(tog_sync_reg != tog_prev_reg);
	assign byte_done = slave_byte_done ||
		(ce && ctrl.interface_enable && master_enable && master_byte_done);

	// R1 mode fault detect
	assign mode_fault_flag_set = ce && ctrl.interface_enable && master_enable &&
		ctrl.select_mode_field == SPICSF_SEL_FOUR_WIRE_SLAVE && !nss_sync_reg;

	// R3 slave overrun detect
	assign ovr_set = slave_byte_done && rx_full && !data_rd;

	assign write_collision_flag_set = ce && ctrl.interface_enable && data_wr && !ctrl.transmit_buffer_empty;

	assign cur_byte = ctrl;
	assign hit_wr = (sfr_req.wr || sfr_req.bit_wr) && sfr_req.addr == SPICSF_CTRL_ADDR;

	// Bit access rewrites one bit of the current value, byte access the whole byte.
	always_comb begin
		wr_byte = cur_byte;
		if (sfr_req.wr) begin
			wr_byte = sfr_req.wdata;
		end else if (sfr_req.bit_wr) begin
			wr_byte[sfr_req.bit_idx] = sfr_req.bit_val;
		end
	end

	// Hardware sets beat a software clear in the same cycle so no event is lost.
	always_comb begin
		ctrl_next = ctrl;
		if (hit_wr) begin
			ctrl_next.transfer_done_flag = wr_byte[SPICSF_BIT_DONE];
			ctrl_next.write_collision_flag = wr_byte[SPICSF_BIT_WRITE_COLLISION_FLAG];
			// R2 software-only clear
			ctrl_next.mode_fault_flag = wr_byte[SPICSF_BIT_MODE_FAULT_FLAG];
			ctrl_next.receive_overrun_flag = wr_byte[SPICSF_BIT_OVR];
			ctrl_next.select_mode_field = wr_byte[SPICSF_BIT_SEL_HI:SPICSF_BIT_SEL_LO];
			// R4 enable bit write
			ctrl_next.interface_enable = wr_byte[SPICSF_BIT_EN];
		end
		// R5 done flag sticky
		if (byte_done) begin
			ctrl_next.transfer_done_flag = 1'b1;
		end
		if (write_collision_flag_set) begin
			ctrl_next.write_collision_flag = 1'b1;
		end
		// R1 mode fault set
		if (mode_fault_flag_set) begin
			ctrl_next.mode_fault_flag = 1'b1;
		end
		// R3 overrun set
		if (ovr_set) begin
			ctrl_next.receive_overrun_flag = 1'b1;
		end
		if (ce && ctrl.interface_enable && data_wr && ctrl.transmit_buffer_empty) begin
			ctrl_next.transmit_buffer_empty = 1'b0;
		end else if (ce && tx_load) begin
			ctrl_next.transmit_buffer_empty = 1'b1;
		end
	end

	// R4 reset disables
	always_ff @(posedge clk) begin
		if (!rstn) begin
			ctrl <= SPICSF_CTRL_RESET;
		end else if (ce) begin
			ctrl <= ctrl_next;
		end
	end

	// A collided write is dropped so the byte being shifted out is not corrupted.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			tx_data <= '0;
		end else if (ce && ctrl.interface_enable && data_wr && ctrl.transmit_buffer_empty) begin
			tx_data <= data_wdata;
		end
	end

	// R3 receive buffer state
	always_ff @(posedge clk) begin
		if (!rstn) begin
			rx_data <= '0;
			rx_full <= 1'b0;
		end else if (ce) begin
			if (slave_byte_done && !(rx_full && !data_rd)) begin
				rx_data <= link_byte;
				rx_full <= 1'b1;
			end else if (data_rd) begin
				rx_full <= 1'b0;
			end
		end
	end

	// Read data is registered; an unmapped address reads as zero.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			sfr_rdata <= SPICSF_ZERO_BYTE;
		end else if (ce && sfr_req.rd) begin
			sfr_rdata <= (sfr_req.addr == SPICSF_CTRL_ADDR) ? cur_byte : SPICSF_ZERO_BYTE;
		end
	end

	// R1 interrupt request
	always_ff @(posedge clk) begin
		if (!rstn) begin
			irq_request <= 1'b0;
		end else if (ce) begin
			irq_request <= ctrl_next.transfer_done_flag | ctrl_next.write_collision_flag |
				ctrl_next.mode_fault_flag | ctrl_next.receive_overrun_flag;
		end
	end
endmodule : spicsf_top

// ==== spicsf_top_assertions.sv ====
// Checker of the enable and flag behaviour at the serial port top.
`timescale 1ns/1ps
module spicsf_top_assertions
	import spicsf_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	input wire logic ce,
	// Watched ports
	input wire spicsf_sfr_req_t sfr_req,
	input wire logic master_byte_done,
	input wire logic master_enable,
	input wire logic slave_select_input_n,
	input wire spicsf_ctrl_t ctrl,
	input wire logic irq_request
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	wire logic sw = sfr_req.wr | sfr_req.bit_wr;
	sequence fault_cond;
		ce && ctrl.interface_enable && master_enable && !slave_select_input_n
			&& ctrl.select_mode_field == 2'h1;
	endsequence
	// The select pin passes a synchroniser, so the flag may lag the pin.
	mode_fault_a: assert property (fault_cond [*4] |-> ##[0:2] ctrl.mode_fault_flag)
		else $error("mode fault flag not raised");
	irq_flags_a: assert property (irq_request == (ctrl[7:4] != 4'h0))
		else $error("interrupt request differs from flags");
	mode_fault_flag_hold_a: assert property (ctrl.mode_fault_flag && !sw |=> ctrl.mode_fault_flag)
		else $error("mode fault flag lost");
	slave_only_a: assert property (master_enable && !ctrl.receive_overrun_flag && !sw
		|=> !ctrl.receive_overrun_flag) else $error("overrun set in master mode");
	reset_value_a: assert property (disable iff (1'b0) !rstn |=> ctrl == SPICSF_CTRL_RESET)
		else $error("control reset value wrong");
	disabled_idle_a: assert property (!ctrl.interface_enable && !ctrl.transfer_done_flag
		&& !sw && !master_byte_done |=> !ctrl.transfer_done_flag) else $error("done while off");
	done_set_a: assert property (ce && ctrl.interface_enable && master_enable && master_byte_done
		|=> ctrl.transfer_done_flag) else $error("done flag not set");
	done_hold_a: assert property (ctrl.transfer_done_flag && !sw |=> ctrl.transfer_done_flag)
		else $error("done flag lost");
endmodule : spicsf_top_assertions

bind spicsf_top spicsf_top_assertions i_spicsf_top_assertions (.clk, .rstn, .ce, .sfr_req,
	.master_byte_done, .master_enable, .slave_select_input_n, .ctrl, .irq_request);

// ==== spicsf_peer.sv ====
// Model of the far serial master that drives select, clock and data.
`timescale 1ns/1ps
module spicsf_peer (
	// Link pins towards the port
	output logic sck,
	output logic slave_select_input_n,
	output logic mosi
);
	// The link logic resets on its own clock, so a few edges run before any frame.
	initial begin
		sck = 1'b0;
		slave_select_input_n = 1'b1;
		mosi = 1'b1;
		repeat (6) #32 sck = ~sck;
	end
	task automatic send(input logic [7:0] b);
		slave_select_input_n = 1'b0;
		#50;
		for (int i = 7; i >= 0; i--) begin
			mosi = b[i];
			#32 sck = 1'b1;
			#32 sck = 1'b0;
		end
		#50 slave_select_input_n = 1'b1;
		mosi = ~mosi;
	endtask : send
	// The link leaves reset two of its own edges after release, so idle edges precede a frame.
	task automatic warm(input int n);
		repeat (n) begin
			#32 sck = 1'b1;
			#32 sck = 1'b0;
		end
	endtask : warm
	task automatic hold_select(input logic v);
		slave_select_input_n = v;
	endtask : hold_select
endmodule : spicsf_peer

// ==== spicsf_top_tb_top.sv ====
// Testbench for the serial port control and status flags.
`timescale 1ns/1ps
module spicsf_top_tb_top;
	import spicsf_pkg::*;
	logic clk, rstn, ce, data_wr, data_rd, tx_load, master_byte_done, master_enable;
	logic sck, slave_select_input_n, mosi, rx_full, irq_request;
	logic [7:0] data_wdata, sfr_rdata, tx_data, rx_data;
	spicsf_sfr_req_t sfr_req;
	spicsf_ctrl_t ctrl;
	int error_cnt = 0;
	int n_tests = 0;
	spicsf_top i_spicsf_top (.clk, .rstn, .ce, .sfr_req, .sfr_rdata, .data_wr, .data_wdata,
		.data_rd, .tx_load, .master_byte_done, .master_enable, .sck, .slave_select_input_n,
		.mosi, .ctrl, .tx_data, .rx_data, .rx_full, .irq_request);
	spicsf_peer i_spicsf_peer (.sck, .slave_select_input_n, .mosi);
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic pulse_wr(input logic [7:0] d);
		data_wdata = d;
		data_wr = 1'b1;
		tick(1);
		data_wr = 1'b0;
		tick(1);
	endtask : pulse_wr
	// Kind 0 reads, 1 writes a byte, 2 writes bit d[2:0] with value d[3].
	task automatic acc(input logic [7:0] a, input logic [7:0] d, input int k);
		tick(1);
		sfr_req = '{a, d, k == 1, k == 0, k == 2, d[2:0], d[3]};
		tick(1);
		sfr_req = '0;
	endtask : acc
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : final_report
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		#200000;
		error_cnt++;
		final_report();
	end
	initial begin
		rstn = 1'b0;
		ce = 1'b1;
		data_wr = 1'b0;
		data_rd = 1'b0;
		tx_load = 1'b0;
		master_byte_done = 1'b0;
		master_enable = 1'b0;
		data_wdata = 8'h00;
		sfr_req = '0;
		tick(20);
		rstn = 1'b1;
		chk(ctrl, 8'h06);
		acc(8'hF8, 8'h00, 0);
		chk(sfr_rdata, 8'h06);
		acc(8'h10, 8'h00, 0);
		chk(sfr_rdata, 8'h00);
		acc(8'hF8, 8'h05, 1);
		chk(ctrl, 8'h07);
		$display("reset test done");
		master_enable = 1'b1;
		i_spicsf_peer.hold_select(1'b0);
		tick(6);
		chk(ctrl, 8'h27);
		chk(8'(irq_request), 8'h01);
		i_spicsf_peer.hold_select(1'b1);
		tick(6);
		chk(ctrl, 8'h27);
		acc(8'hF8, 8'h05, 2);
		chk(ctrl, 8'h07);
		acc(8'hF8, 8'h01, 1);
		i_spicsf_peer.hold_select(1'b0);
		tick(6);
		chk(ctrl, 8'h03);
		chk(8'(irq_request), 8'h00);
		i_spicsf_peer.hold_select(1'b1);
		tick(4);
		acc(8'hF8, 8'h05, 1);
		chk(ctrl, 8'h07);
		$display("mode fault test done");
		ce = 1'b0;
		master_byte_done = 1'b1;
		tick(1);
		ce = 1'b1;
		master_byte_done = 1'b0;
		chk(ctrl, 8'h07);
		master_byte_done = 1'b1;
		tick(1);
		master_byte_done = 1'b0;
		chk(ctrl, 8'h87);
		tick(5);
		chk(ctrl, 8'h87);
		acc(8'hF8, 8'h07, 2);
		chk(ctrl, 8'h07);
		master_enable = 1'b0;
		$display("master done test done");
		i_spicsf_peer.warm(2);
		i_spicsf_peer.send(8'hA5);
		for (int i = 0; i < 50 && rx_full !== 1'b1; i++) tick(1);
		chk(rx_data, 8'hA5);
		chk(ctrl, 8'h87);
		i_spicsf_peer.send(8'h3C);
		tick(8);
		chk(ctrl, 8'h97);
		chk(rx_data, 8'hA5);
		data_rd = 1'b1;
		tick(1);
		data_rd = 1'b0;
		chk(8'(rx_full), 8'h00);
		acc(8'hF8, 8'h05, 1);
		chk(ctrl, 8'h07);
		$display("slave overrun test done");
		acc(8'hF8, 8'h04, 1);
		chk(ctrl, 8'h06);
		i_spicsf_peer.send(8'h66);
		tick(8);
		chk(8'(rx_full), 8'h00);
		chk(ctrl, 8'h06);
		$display("disable test done");
		pulse_wr(8'h5A);
		chk(tx_data, 8'h00);
		chk(ctrl, 8'h06);
		acc(8'hF8, 8'h05, 1);
		pulse_wr(8'h5A);
		chk(tx_data, 8'h5A);
		chk(ctrl, 8'h05);
		pulse_wr(8'hC3);
		chk(tx_data, 8'h5A);
		chk(ctrl, 8'h45);
		chk(8'(irq_request), 8'h01);
		tx_load = 1'b1;
		tick(1);
		tx_load = 1'b0;
		chk(ctrl, 8'h47);
		acc(8'hF8, 8'h06, 2);
		chk(ctrl, 8'h07);
		$display("data write test done");
		final_report();
	end
endmodule : spicsf_top_tb_top
